// ---- rac_pkg.sv ----
`default_nettype none
package rac_pkg;

    // Command frame selection, bytes 1 and 2
    localparam logic [7:0]  RAC_CMD_ADJUSTING_CODE = 8'h3E;
    localparam logic [7:0]  RAC_CMD_ADJUSTING_SEL  = 8'h00;

    // Sub-command codes, byte 5
    localparam logic [7:0]  RAC_SUB_READ           = 8'h00;
    localparam logic [7:0]  RAC_SUB_WRITE          = 8'h01;

    // Setting address of the rigidity level
    localparam logic [15:0] RAC_ADDR_RIGIDITY      = 16'h2003;

    // Rigidity level range and reset value
    localparam logic [3:0]  RAC_LEVEL_MIN          = 4'h1;
    localparam logic [3:0]  RAC_LEVEL_MAX          = 4'hA;
    localparam logic [3:0]  RAC_LEVEL_RESET        = 4'h4;

    // Apply time: one second at the system clock
    localparam int          RAC_APPLY_TIME_S       = 32'h0000_0001;
    localparam int          RAC_CLK_FREQ_HZ        = 32'h0773_5940;
    localparam int          RAC_APPLY_CYCLES       = RAC_APPLY_TIME_S * RAC_CLK_FREQ_HZ;

    // Direct gain parameter select
    typedef enum logic [1:0] {
        RAC_SEL_POS_GAIN,
        RAC_SEL_SPEED_GAIN,
        RAC_SEL_INTEG_TIME,
        RAC_SEL_FILT_TIME
    } rac_param_sel_t;

    // Gain targets for levels 10 down to 1
    localparam logic [9:0][15:0] RAC_LOOP_GAIN_TBL = {
        16'h00FA, 16'h00C8, 16'h00A0, 16'h0078, 16'h0055,
        16'h003C, 16'h0028, 16'h001E, 16'h0014, 16'h000F};
    localparam logic [9:0][15:0] RAC_INTEG_TIME_TBL = {
        16'h0190, 16'h01F4, 16'h0258, 16'h0320, 16'h03E8,
        16'h05DC, 16'h07D0, 16'h0BB8, 16'h1194, 16'h1770};
    localparam logic [9:0][15:0] RAC_FILT_TIME_TBL = {
        16'h000A, 16'h000F, 16'h0014, 16'h001E, 16'h0032,
        16'h0046, 16'h0064, 16'h0082, 16'h00C8, 16'h00FA};

    function automatic logic rac_level_ok(input logic [15:0] value);
        rac_level_ok = (value >= {12'h000, RAC_LEVEL_MIN}) && (value <= {12'h000, RAC_LEVEL_MAX});
    endfunction

    // Out-of-range levels fall back to the reset level
    function automatic logic [3:0] rac_level_index(input logic [3:0] level);
        if ((level >= RAC_LEVEL_MIN) && (level <= RAC_LEVEL_MAX)) begin
            rac_level_index = level - 4'h1;
        end else begin
            rac_level_index = RAC_LEVEL_RESET - 4'h1;
        end
    endfunction

endpackage
`default_nettype wire

// ---- rac_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface rac_gain_if;
    logic [3:0]  level;
    logic [15:0] pos_gain;
    logic [15:0] speed_gain;
    logic [15:0] integ_time;
    logic [15:0] filt_time;
    modport table_side (input level, output pos_gain, speed_gain, integ_time, filt_time);
    modport user_side  (output level, input pos_gain, speed_gain, integ_time, filt_time);
endinterface

interface rac_timer_if;
    logic start;
    logic busy;
    logic done;
    modport timer_side (input start, output busy, done);
    modport user_side  (output start, input busy, done);
endinterface

`default_nettype wire

// ---- rac_gain_table.sv ----
`timescale 1ns/10ps
`default_nettype none

module rac_gain_table
    import rac_pkg::*;
(
    rac_gain_if.table_side gif
);
    logic [3:0] idx;

    always_comb begin
        idx            = rac_level_index(gif.level);
        gif.pos_gain   = RAC_LOOP_GAIN_TBL[idx];
        gif.speed_gain = RAC_LOOP_GAIN_TBL[idx];
        gif.integ_time = RAC_INTEG_TIME_TBL[idx];
        gif.filt_time  = RAC_FILT_TIME_TBL[idx];
    end

endmodule
`default_nettype wire

// ---- rac_settle_timer.sv ----
`timescale 1ns/10ps
`default_nettype none

module rac_settle_timer
    import rac_pkg::*;
#(
    parameter int CYCLES = RAC_APPLY_CYCLES
)
(
    // Clock and reset
    input  wire logic   mclk_i,
    input  wire logic   rst_b_i,
    // Control
    rac_timer_if.timer_side tif
);
    localparam int W = $clog2(CYCLES + 1);

    typedef struct packed {
        logic         busy;
        logic         done;
        logic [W-1:0] cnt;
    } rac_timer_state_t;

    rac_timer_state_t st;
    rac_timer_state_t next_st;

    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        if (st.busy) begin
            if (st.cnt == '0) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.cnt = st.cnt - 1'b1;
            end
        end else if (tif.start) begin
            next_st.busy = 1'b1;
            next_st.cnt  = W'(CYCLES - 1);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tif.busy = st.busy;
    assign tif.done = st.done;

    a_settle_bound: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        st.busy |-> (st.cnt < W'(CYCLES)))
        else $error("settle counter beyond apply time");

    a_done_single: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        st.done |-> !st.busy ##1 !st.done)
        else $error("apply done not a single pulse");

endmodule
`default_nettype wire

// ---- rac_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module rac_top
    import rac_pkg::*;
#(
    parameter int APPLY_CYCLES = RAC_APPLY_CYCLES
)
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    // Command frame
    input  wire logic        cmd_valid_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic [7:0]  cmd_sel_i,
    input  wire logic [7:0]  sub_command_code_i,
    input  wire logic [15:0] setting_address_i,
    input  wire logic [15:0] setting_value_i,
    // Response frame
    output logic             rsp_valid_o,
    output logic [7:0]       sub_answer_code_o,
    output logic [15:0]      rsp_setting_address_o,
    output logic [15:0]      rsp_setting_value_o,
    output logic             rsp_alarm_o,
    output logic             rsp_warning_o,
    output logic             command_accepted_flag_o,
    // Direct gain parameter writes
    input  wire logic        autotune_en_i,
    input  wire logic        param_wr_i,
    input  wire logic [1:0]  param_sel_i,
    input  wire logic [15:0] param_val_i,
    // Tuning targets
    output logic [3:0]       rigidity_level_o,
    output logic [15:0]      position_loop_gain_param_o,
    output logic [15:0]      speed_loop_gain_param_o,
    output logic [15:0]      speed_integral_time_param_o,
    output logic [15:0]      torque_filter_time_param_o
);

    typedef struct packed {
        logic        rsp_valid;
        logic [7:0]  answer;
        logic [15:0] addr;
        logic [15:0] value;
        logic        alarm;
        logic        warning;
        logic [3:0]  level;
        logic [3:0]  pending;
        logic [15:0] pos_gain;
        logic [15:0] speed_gain;
        logic [15:0] integ_time;
        logic [15:0] filt_time;
    } rac_top_state_t;

    localparam logic [3:0] RST_IDX = RAC_LEVEL_RESET - 4'h1;

    localparam rac_top_state_t RESET_STATE = '{
        rsp_valid:  1'b0,
        answer:     8'h00,
        addr:       16'h0000,
        value:      16'h0000,
        alarm:      1'b0,
        warning:    1'b0,
        level:      RAC_LEVEL_RESET,
        pending:    RAC_LEVEL_RESET,
        pos_gain:   RAC_LOOP_GAIN_TBL[RST_IDX],
        speed_gain: RAC_LOOP_GAIN_TBL[RST_IDX],
        integ_time: RAC_INTEG_TIME_TBL[RST_IDX],
        filt_time:  RAC_FILT_TIME_TBL[RST_IDX]
    };

    rac_top_state_t st;
    rac_top_state_t next_st;
    logic           is_adjusting;

    rac_gain_if  gif ();
    rac_timer_if tif ();

    rac_gain_table u_table (
        .gif (gif)
    );

    rac_settle_timer #(
        .CYCLES (APPLY_CYCLES)
    ) u_timer (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .tif     (tif)
    );

    // Table looks up the level being applied, not the one in force
    assign gif.level = st.pending;

    // Other command codes belong to other handlers and get no answer here
    assign is_adjusting = cmd_valid_i && (cmd_code_i == RAC_CMD_ADJUSTING_CODE)
                          && (cmd_sel_i == RAC_CMD_ADJUSTING_SEL);

    always_comb begin
        next_st           = st;
        next_st.rsp_valid = 1'b0;
        tif.start         = 1'b0;
        if (is_adjusting) begin
            next_st.rsp_valid = 1'b1;
            next_st.answer    = sub_command_code_i;
            next_st.addr      = setting_address_i;
            next_st.value     = 16'h0000;
            next_st.alarm     = 1'b0;
            next_st.warning   = 1'b0;
            case (sub_command_code_i)
                RAC_SUB_READ: begin
                    if (setting_address_i == RAC_ADDR_RIGIDITY) begin
                        next_st.value = {12'h000, st.level};
                    end else begin
                        next_st.alarm = 1'b1;
                    end
                end
                RAC_SUB_WRITE: begin
                    next_st.value = setting_value_i;
                    if (setting_address_i != RAC_ADDR_RIGIDITY) begin
                        next_st.alarm = 1'b1;
                    end else if (!rac_level_ok(setting_value_i)) begin
                        next_st.warning = 1'b1;
                    end else if (tif.busy) begin
                        // A second write cannot overtake one still settling
                        next_st.warning = 1'b1;
                    end else begin
                        next_st.pending = setting_value_i[3:0];
                        tif.start       = 1'b1;
                    end
                end
                default: begin
                    next_st.alarm = 1'b1;
                end
            endcase
        end
        if (tif.done) begin
            next_st.level      = st.pending;
            next_st.pos_gain   = gif.pos_gain;
            next_st.speed_gain = gif.speed_gain;
            next_st.integ_time = gif.integ_time;
            next_st.filt_time  = gif.filt_time;
        end
        // A direct write in the same cycle as an apply wins
        if (param_wr_i && autotune_en_i) begin
            case (param_sel_i)
                RAC_SEL_POS_GAIN: begin
                    next_st.pos_gain = param_val_i;
                end
                RAC_SEL_SPEED_GAIN: begin
                    next_st.speed_gain = param_val_i;
                end
                RAC_SEL_INTEG_TIME: begin
                    next_st.integ_time = param_val_i;
                end
                RAC_SEL_FILT_TIME: begin
                    next_st.filt_time = param_val_i;
                end
                default: begin
                    next_st.pos_gain = st.pos_gain;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            st <= RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    assign rsp_valid_o                 = st.rsp_valid;
    assign sub_answer_code_o           = st.answer;
    assign rsp_setting_address_o       = st.addr;
    assign rsp_setting_value_o         = st.value;
    assign rsp_alarm_o                 = st.alarm;
    assign rsp_warning_o               = st.warning;
    assign command_accepted_flag_o     = !tif.busy;
    assign rigidity_level_o            = st.level;
    assign position_loop_gain_param_o  = st.pos_gain;
    assign speed_loop_gain_param_o     = st.speed_gain;
    assign speed_integral_time_param_o = st.integ_time;
    assign torque_filter_time_param_o  = st.filt_time;

    default clocking cb @(posedge mclk_i);
    endclocking

    default disable iff (!rst_b_i);

    a_adj_answered: assert property (
        is_adjusting |=> rsp_valid_o)
        else $error("adjusting command not answered");

    a_other_ignored: assert property (
        cmd_valid_i && (cmd_code_i != RAC_CMD_ADJUSTING_CODE) |=> !rsp_valid_o)
        else $error("non-adjusting command answered");

    a_answer_echo: assert property (
        is_adjusting |=> (sub_answer_code_o == $past(sub_command_code_i))
                         && (rsp_setting_address_o == $past(setting_address_i)))
        else $error("answer code or address not echoed");

    a_write_echo: assert property (
        is_adjusting && (sub_command_code_i == RAC_SUB_WRITE)
        |=> rsp_setting_value_o == $past(setting_value_i))
        else $error("written value not echoed");

    a_read_level: assert property (
        is_adjusting && (sub_command_code_i == RAC_SUB_READ)
        && (setting_address_i == RAC_ADDR_RIGIDITY)
        |=> (rsp_setting_value_o == {12'h000, $past(st.level)}) && !rsp_alarm_o)
        else $error("rigidity read returns wrong value");

    a_good_write_clean: assert property (
        is_adjusting && (sub_command_code_i == RAC_SUB_WRITE) && !tif.busy
        && (setting_address_i == RAC_ADDR_RIGIDITY) && rac_level_ok(setting_value_i)
        |=> !rsp_alarm_o && !rsp_warning_o && !command_accepted_flag_o)
        else $error("accepted write shows bad status or stays ready");

    a_bad_value_flagged: assert property (
        is_adjusting && (sub_command_code_i == RAC_SUB_WRITE)
        && (setting_address_i == RAC_ADDR_RIGIDITY) && !rac_level_ok(setting_value_i)
        |=> rsp_warning_o && (st.pending == $past(st.pending)))
        else $error("out-of-range level not refused");

    a_stray_answer: assert property (
        !is_adjusting |=> !rsp_valid_o)
        else $error("response without adjusting command");

    a_unknown_sub: assert property (
        is_adjusting && (sub_command_code_i != RAC_SUB_READ) && (sub_command_code_i != RAC_SUB_WRITE)
        |=> rsp_alarm_o)
        else $error("unknown sub-command not flagged");

    a_bad_addr_alarm: assert property (
        is_adjusting && (sub_command_code_i == RAC_SUB_WRITE) && (setting_address_i != RAC_ADDR_RIGIDITY)
        |=> rsp_alarm_o && (st.pending == $past(st.pending)))
        else $error("write to unmapped address not refused");

    a_busy_refused: assert property (
        is_adjusting && (sub_command_code_i == RAC_SUB_WRITE) && tif.busy
        && (setting_address_i == RAC_ADDR_RIGIDITY)
        |=> rsp_warning_o && (st.pending == $past(st.pending)))
        else $error("write during settling overtook the first");

    a_level_range: assert property (
        (rigidity_level_o >= RAC_LEVEL_MIN) && (rigidity_level_o <= RAC_LEVEL_MAX))
        else $error("rigidity level out of range");

    a_level_applied: assert property (
        $changed(rigidity_level_o) |-> $past(tif.done))
        else $error("level changed before apply finished");

    a_apply_takes: assert property (
        tif.done |=> rigidity_level_o == $past(st.pending))
        else $error("applied level differs from written");

    a_reset_level: assert property (@(posedge mclk_i) disable iff (1'b0)
        $rose(rst_b_i) |-> (rigidity_level_o == RAC_LEVEL_RESET)
                           && (speed_integral_time_param_o == RAC_INTEG_TIME_TBL[RST_IDX]))
        else $error("reset level is not four");

    a_loop_gain_map: assert property (
        $past(tif.done) && !$past(param_wr_i)
        |-> (position_loop_gain_param_o == RAC_LOOP_GAIN_TBL[rac_level_index(rigidity_level_o)])
            && (speed_loop_gain_param_o == RAC_LOOP_GAIN_TBL[rac_level_index(rigidity_level_o)]))
        else $error("loop gains do not match level");

    a_integ_map: assert property (
        $past(tif.done) && !$past(param_wr_i)
        |-> speed_integral_time_param_o == RAC_INTEG_TIME_TBL[rac_level_index(rigidity_level_o)])
        else $error("integral time does not match level");

    a_filt_map: assert property (
        $past(tif.done) && !$past(param_wr_i)
        |-> torque_filter_time_param_o == RAC_FILT_TIME_TBL[rac_level_index(rigidity_level_o)])
        else $error("filter time does not match level");

    a_direct_adopt: assert property (
        param_wr_i && autotune_en_i && (param_sel_i == RAC_SEL_INTEG_TIME)
        |=> speed_integral_time_param_o == $past(param_val_i))
        else $error("direct write not adopted as target");

    a_direct_pos: assert property (
        param_wr_i && autotune_en_i && (param_sel_i == RAC_SEL_POS_GAIN)
        |=> position_loop_gain_param_o == $past(param_val_i))
        else $error("direct position gain not adopted");

    a_direct_ignored: assert property (
        param_wr_i && !autotune_en_i && !tif.done
        |=> position_loop_gain_param_o == $past(position_loop_gain_param_o))
        else $error("direct write adopted with autotuning off");

endmodule
`default_nettype wire

// ---- rac_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module rac_host_model
    import rac_pkg::*;
(
    // Clock
    input  wire logic        mclk_i,
    // Command frame
    output logic             cmd_valid_o,
    output logic [7:0]       cmd_code_o,
    output logic [7:0]       cmd_sel_o,
    output logic [7:0]       sub_command_code_o,
    output logic [15:0]      setting_address_o,
    output logic [15:0]      setting_value_o,
    // Response frame
    input  wire logic        rsp_valid_i,
    input  wire logic [7:0]  sub_answer_code_i,
    input  wire logic [15:0] rsp_setting_address_i,
    input  wire logic [15:0] rsp_setting_value_i,
    input  wire logic        rsp_alarm_i,
    input  wire logic        rsp_warning_i,
    input  wire logic        command_accepted_flag_i
);
    logic        r_valid;
    logic [7:0]  r_ans;
    logic [15:0] r_addr;
    logic [15:0] r_val;
    logic        r_alarm;
    logic        r_warn;
    logic        r_rdy;

    initial begin
        cmd_valid_o        = 1'b0;
        cmd_code_o         = 8'h00;
        cmd_sel_o          = 8'hFF;
        sub_command_code_o = 8'hFF;
        setting_address_o  = 16'hFFFF;
        setting_value_o    = 16'hFFFF;
    end

    // One frame: fields held through the taking edge, response sampled one cycle later
    task automatic send(input logic [7:0] code, input logic [7:0] sel, input logic [7:0] sub,
                        input logic [15:0] addr, input logic [15:0] val);
        @(negedge mclk_i);
        cmd_valid_o        = 1'b1;
        cmd_code_o         = code;
        cmd_sel_o          = sel;
        sub_command_code_o = sub;
        setting_address_o  = addr;
        setting_value_o    = val;
        @(negedge mclk_i);
        r_valid = rsp_valid_i;
        r_ans   = sub_answer_code_i;
        r_addr  = rsp_setting_address_i;
        r_val   = rsp_setting_value_i;
        r_alarm = rsp_alarm_i;
        r_warn  = rsp_warning_i;
        r_rdy   = command_accepted_flag_i;
        // Released lines show the inverse so stale fields are never mistaken for a frame
        cmd_valid_o        = 1'b0;
        cmd_code_o         = ~code;
        cmd_sel_o          = ~sel;
        sub_command_code_o = ~sub;
        setting_address_o  = ~addr;
        setting_value_o    = ~val;
    endtask
endmodule

`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb
    import rac_pkg::*;
;
    localparam int APPLY = 32'h0000_0014;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic cmd_valid, rsp_valid, alarm, warn, rdy, at_en = 1'b0, pwr = 1'b0;
    logic [7:0] code, sel, sub, ans;
    logic [15:0] addr, val, raddr, rval, pval = 16'h0000;
    logic [1:0] psel = 2'h0;
    logic [3:0] lvl;
    logic [15:0] tgt [4];
    int errors = 0;
    int compares = 0;
    logic [15:0] e_gain [10] = '{16'h000F, 16'h0014, 16'h001E, 16'h0028, 16'h003C,
                                 16'h0055, 16'h0078, 16'h00A0, 16'h00C8, 16'h00FA};
    logic [15:0] e_integ [10] = '{16'h1770, 16'h1194, 16'h0BB8, 16'h07D0, 16'h05DC,
                                  16'h03E8, 16'h0320, 16'h0258, 16'h01F4, 16'h0190};
    logic [15:0] e_filt [10] = '{16'h00FA, 16'h00C8, 16'h0082, 16'h0064, 16'h0046,
                                 16'h0032, 16'h001E, 16'h0014, 16'h000F, 16'h000A};

    always #4 mclk_i = ~mclk_i;

    rac_top #(.APPLY_CYCLES(APPLY)) i_rac_top (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid), .cmd_code_i(code),
        .cmd_sel_i(sel), .sub_command_code_i(sub), .setting_address_i(addr), .setting_value_i(val),
        .rsp_valid_o(rsp_valid), .sub_answer_code_o(ans), .rsp_setting_address_o(raddr),
        .rsp_setting_value_o(rval), .rsp_alarm_o(alarm), .rsp_warning_o(warn),
        .command_accepted_flag_o(rdy), .autotune_en_i(at_en), .param_wr_i(pwr), .param_sel_i(psel),
        .param_val_i(pval), .rigidity_level_o(lvl), .position_loop_gain_param_o(tgt[0]),
        .speed_loop_gain_param_o(tgt[1]), .speed_integral_time_param_o(tgt[2]),
        .torque_filter_time_param_o(tgt[3]));

    rac_host_model i_rac_host_model (
        .mclk_i(mclk_i), .cmd_valid_o(cmd_valid), .cmd_code_o(code), .cmd_sel_o(sel),
        .sub_command_code_o(sub), .setting_address_o(addr), .setting_value_o(val),
        .rsp_valid_i(rsp_valid), .sub_answer_code_i(ans), .rsp_setting_address_i(raddr),
        .rsp_setting_value_i(rval), .rsp_alarm_i(alarm), .rsp_warning_i(warn),
        .command_accepted_flag_i(rdy));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic adjusting_command(input logic [7:0] s, input logic [15:0] a, input logic [15:0] v);
        i_rac_host_model.send(RAC_CMD_ADJUSTING_CODE, RAC_CMD_ADJUSTING_SEL, s, a, v);
    endtask

    // Response fields: valid, answer, address, value, alarm, warning, ready
    task automatic chk_rsp(input logic [7:0] s, input logic [15:0] a, input logic [15:0] v,
                           input logic al, input logic wn, input logic rd);
        chk("rsp_valid", 16'h0001, {15'h0000, i_rac_host_model.r_valid});
        chk("answer", {8'h00, s}, {8'h00, i_rac_host_model.r_ans});
        chk("address", a, i_rac_host_model.r_addr);
        chk("value", v, i_rac_host_model.r_val);
        chk("alarm", {15'h0000, al}, {15'h0000, i_rac_host_model.r_alarm});
        chk("warning", {15'h0000, wn}, {15'h0000, i_rac_host_model.r_warn});
        chk("ready", {15'h0000, rd}, {15'h0000, i_rac_host_model.r_rdy});
    endtask

    task automatic chk_level(input int n);
        chk("level", 16'(n), {12'h000, lvl});
        chk("pos_gain", e_gain[n-1], tgt[0]);
        chk("speed_gain", e_gain[n-1], tgt[1]);
        chk("integ_time", e_integ[n-1], tgt[2]);
        chk("filt_time", e_filt[n-1], tgt[3]);
    endtask

    task automatic t_reset();
        chk_level(4);
        chk("ready", 16'h0001, {15'h0000, rdy});
        $display("test reset done");
    endtask

    // Write every level, read back old level while settling, new level once applied
    task automatic t_levels();
        int old;
        old = 4;
        for (int n = 1; n <= 10; n++) begin
            adjusting_command(RAC_SUB_WRITE, RAC_ADDR_RIGIDITY, 16'(n));
            chk_rsp(RAC_SUB_WRITE, RAC_ADDR_RIGIDITY, 16'(n), 1'b0, 1'b0, 1'b0);
            adjusting_command(RAC_SUB_READ, RAC_ADDR_RIGIDITY, 16'h0000);
            chk_rsp(RAC_SUB_READ, RAC_ADDR_RIGIDITY, 16'(old), 1'b0, 1'b0, 1'b0);
            chk_level(old);
            // Host waits out the apply time before judging the change
            repeat (APPLY) @(negedge mclk_i);
            chk_level(n);
            adjusting_command(RAC_SUB_READ, RAC_ADDR_RIGIDITY, 16'h0000);
            chk_rsp(RAC_SUB_READ, RAC_ADDR_RIGIDITY, 16'(n), 1'b0, 1'b0, 1'b1);
            old = n;
        end
        $display("test levels done");
    endtask

    task automatic t_refuse();
        adjusting_command(RAC_SUB_WRITE, RAC_ADDR_RIGIDITY, 16'h0000);
        chk_rsp(RAC_SUB_WRITE, RAC_ADDR_RIGIDITY, 16'h0000, 1'b0, 1'b1, 1'b1);
        adjusting_command(RAC_SUB_WRITE, RAC_ADDR_RIGIDITY, 16'h000B);
        chk_rsp(RAC_SUB_WRITE, RAC_ADDR_RIGIDITY, 16'h000B, 1'b0, 1'b1, 1'b1);
        adjusting_command(RAC_SUB_READ, 16'h2004, 16'h0000);
        chk_rsp(RAC_SUB_READ, 16'h2004, 16'h0000, 1'b1, 1'b0, 1'b1);
        adjusting_command(RAC_SUB_WRITE, 16'h2004, 16'h0005);
        chk_rsp(RAC_SUB_WRITE, 16'h2004, 16'h0005, 1'b1, 1'b0, 1'b1);
        // Unknown sub-commands carry no value back
        adjusting_command(8'h02, RAC_ADDR_RIGIDITY, 16'h0003);
        chk_rsp(8'h02, RAC_ADDR_RIGIDITY, 16'h0000, 1'b1, 1'b0, 1'b1);
        i_rac_host_model.send(8'h3F, RAC_CMD_ADJUSTING_SEL, RAC_SUB_WRITE, RAC_ADDR_RIGIDITY, 16'h0002);
        chk("no_rsp_code", 16'h0000, {15'h0000, i_rac_host_model.r_valid});
        i_rac_host_model.send(RAC_CMD_ADJUSTING_CODE, 8'h01, RAC_SUB_WRITE, RAC_ADDR_RIGIDITY, 16'h0002);
        chk("no_rsp_sel", 16'h0000, {15'h0000, i_rac_host_model.r_valid});
        repeat (APPLY) @(negedge mclk_i);
        chk_level(10);
        // A second write during settling must not overtake the first
        adjusting_command(RAC_SUB_WRITE, RAC_ADDR_RIGIDITY, 16'h0003);
        chk_rsp(RAC_SUB_WRITE, RAC_ADDR_RIGIDITY, 16'h0003, 1'b0, 1'b0, 1'b0);
        adjusting_command(RAC_SUB_WRITE, RAC_ADDR_RIGIDITY, 16'h0007);
        chk_rsp(RAC_SUB_WRITE, RAC_ADDR_RIGIDITY, 16'h0007, 1'b0, 1'b1, 1'b0);
        repeat (APPLY) @(negedge mclk_i);
        chk_level(3);
        $display("test refuse done");
    endtask

    task automatic t_direct();
        @(negedge mclk_i);
        psel = 2'h0;
        pval = 16'h1234;
        pwr = 1'b1;
        @(negedge mclk_i);
        pwr = 1'b0;
        chk("ignored", e_gain[2], tgt[0]);
        at_en = 1'b1;
        for (int s = 0; s < 4; s++) begin
            // One idle edge between strobes keeps each write a single pulse
            @(negedge mclk_i);
            psel = 2'(s);
            pval = 16'h1000 + 16'(s);
            pwr = 1'b1;
            @(negedge mclk_i);
            pwr = 1'b0;
            chk("direct", 16'h1000 + 16'(s), tgt[s]);
        end
        $display("test direct done");
    endtask

    // Reset in mid-run restores the factory level and its targets
    task automatic t_rerst();
        rst_b_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        rst_b_i = 1'b1;
        @(negedge mclk_i);
        chk_level(4);
        chk("ready", 16'h0001, {15'h0000, rdy});
        $display("test rerst done");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(negedge mclk_i);
        rst_b_i = 1'b1;
        @(negedge mclk_i);
        t_reset();
        t_levels();
        t_refuse();
        t_direct();
        t_rerst();
        end_of_test();
    end

    initial begin
        #(8 * 5000);
        errors++;
        end_of_test();
    end
endmodule

`default_nettype wire
